// file: hdl/embedded_array_block.sv
// embedded array block: product-term macrocells or self-timed synchronous ram
// assumes all inputs synchronous to clock; configuration held static
//
// What this block does
// - each block selects memory or product-term use on its own
// - product-term use gives 16 macrocells, two terms and one register each
// - block takes 32 inputs from adjacent local routing
// - nine macrocell outputs loop back into the block inputs
// - control comes from clock pin, global signals and local inputs
// - ten outputs drive local routing, nine of them distinct
// - memory is synchronous, write strobe made inside from global clock
// - memory shapes 128x16, 256x8, 512x4, 1024x2, 2048x1
// - depth up to 2048 words at full speed in one block
// - wider memories by sharing address across side-by-side blocks
// - page decoder enables output driver only for its selected page
`timescale 1ns/1ps

module embedded_array_block
    import embedded_array_pkg::*;
#(
    parameter logic [PAGE_W-1:0] PAGE_ID = '0
) (
    input  wire logic                          clock,
    input  wire logic                          arst_n,
    input  wire logic                          cfg_mode,
    input  wire logic [2:0]                    cfg_shape,
    input  wire logic                          cfg_cascade,
    input  wire logic [NUM_CELLS-1:0]          cfg_cell_reg,
    input  wire logic [2*NUM_CELLS*(NUM_IN+NUM_FEEDBACK)-1:0] cfg_term_mask,
    input  wire logic [NUM_IN-1:0]             local_in,
    input  wire logic                          global_ctl,
    input  wire logic                          local_ctl,
    input  wire logic [ADDR_W-1:0]             addr,
    input  wire logic [PAGE_W-1:0]             page_addr,
    input  wire logic [DATA_W-1:0]             wr_data,
    input  wire logic                          wr_en,
    input  wire logic                          rd_en,
    output logic [DATA_W-1:0]                  rd_data,
    output logic                               rd_data_oe,
    output logic [NUM_CELLS-1:0]               cell_out,
    output logic [NUM_LOCAL_OUT-1:0]           local_out
);
    localparam int TERM_IN = NUM_IN + NUM_FEEDBACK;

    // elaboration check: feedback and local line counts must fit the cells
    if (NUM_FEEDBACK > NUM_CELLS || NUM_LOCAL_OUT != NUM_FEEDBACK + 1) begin : g_bad_counts
        $error("embedded_array_block: bad feedback or local output count");
    end

    // shape decode: data width of the chosen shape
    function automatic logic [4:0] shape_width(input logic [2:0] s);
        case (s)
            SHAPE_128X16: shape_width = 5'h10;
            SHAPE_256X8:  shape_width = 5'h08;
            SHAPE_512X4:  shape_width = 5'h04;
            SHAPE_1024X2: shape_width = 5'h02;
            default:      shape_width = 5'h01;
        endcase
    endfunction

    // clock enable gated by the control inputs
    logic ctl_en;
    assign ctl_en = global_ctl & local_ctl;

    ////////////////////////////////////////////////////////////////////////////
    // memory: one 2048-bit array, addressed per shape
    logic         mem_r [TOTAL_BITS];
    logic         mem_use;
    logic         page_hit;
    logic [4:0]   width;
    logic [10:0]  base;

    assign mem_use  = (cfg_mode == MODE_MEMORY) & ctl_en;
    assign page_hit = !cfg_cascade || (page_addr == PAGE_ID);
    assign width    = shape_width(cfg_shape);

    // bit base: word index times width, with word index wrapped to depth (upper address bits dropped)
    always_comb begin
        case (cfg_shape)
            SHAPE_128X16: base = {addr[6:0], 4'h0};
            SHAPE_256X8:  base = {addr[7:0], 3'h0};
            SHAPE_512X4:  base = {addr[8:0], 2'h0};
            SHAPE_1024X2: base = {addr[9:0], 1'h0};
            default:      base = addr;
        endcase
    end

    // internal write strobe on the global clock edge
    always_ff @(posedge clock) begin
        for (int i = 0; i < DATA_W; i++) begin
            if (mem_use && wr_en && page_hit && (5'(i) < width))
                mem_r[base + 11'(i)] <= wr_data[i];
        end
    end

    // read data and page driver enable
    logic [DATA_W-1:0] rd_data_nxt;
    logic              rd_oe_nxt;
    always_comb begin
        rd_data_nxt = rd_data;
        rd_oe_nxt   = rd_data_oe;
        if (mem_use && rd_en) begin
            for (int i = 0; i < DATA_W; i++)
                rd_data_nxt[i] = (5'(i) < width) ? mem_r[base + 11'(i)] : 1'b0;
            rd_oe_nxt = page_hit;
        end else if (cfg_mode != MODE_MEMORY) begin
            rd_oe_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rd_data    <= DOUT_RESET;
            rd_data_oe <= 1'b0;
        end else begin
            rd_data    <= rd_data_nxt;
            rd_data_oe <= rd_oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // product-term macrocells
    logic [TERM_IN-1:0]   term_in;
    logic [NUM_CELLS-1:0] cell_sum;
    logic [NUM_CELLS-1:0] cell_r;
    logic [NUM_CELLS-1:0] cell_nxt;

    assign term_in = {cell_out[NUM_FEEDBACK-1:0], local_in};

    genvar g;
    generate
        for (g = 0; g < NUM_CELLS; g++) begin : g_cell
            logic [TERM_IN-1:0] m0;
            logic [TERM_IN-1:0] m1;
            assign m0 = cfg_term_mask[(2*g)*TERM_IN +: TERM_IN];
            assign m1 = cfg_term_mask[(2*g+1)*TERM_IN +: TERM_IN];
            // AND of selected inputs per term, then OR of both terms
            assign cell_sum[g] = (&(term_in | ~m0) & |m0) |
                                 (&(term_in | ~m1) & |m1);
        end
    endgenerate

    always_comb begin
        cell_nxt = cell_r;
        if (cfg_mode == MODE_PTERM && ctl_en)
            cell_nxt = cell_sum;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            cell_r <= '0;
        else
            cell_r <= cell_nxt;
    end

    // per-cell choice of register or combinational path
    always_comb begin
        for (int i = 0; i < NUM_CELLS; i++)
            cell_out[i] = (cfg_mode == MODE_PTERM) &
                          (cfg_cell_reg[i] ? cell_r[i] : cell_sum[i]);
    end

    // ten local lines: nine distinct cells, the tenth repeats cell zero
    assign local_out = {cell_out[0], cell_out[NUM_FEEDBACK-1:0]};

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_oe_page;
        @(posedge clock) disable iff (!arst_n)
        (cfg_mode == MODE_MEMORY && ctl_en && rd_en)
        |=> rd_data_oe == (!$past(cfg_cascade) || $past(page_addr) == PAGE_ID);
    endproperty
    a_oe_page: assert property (p_oe_page) else $error("driver on wrong page");

    property p_read_lat;
        @(posedge clock) disable iff (!arst_n)
        (cfg_mode == MODE_MEMORY && ctl_en && rd_en && !wr_en && cfg_shape == SHAPE_2048X1)
        |=> rd_data[0] == mem_r[$past(addr)];
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read data wrong");

    property p_pterm_off;
        @(posedge clock) disable iff (!arst_n)
        cfg_mode == MODE_MEMORY |-> cell_out == '0 && local_out == '0;
    endproperty
    a_pterm_off: assert property (p_pterm_off) else $error("cells active in memory");

    property p_reg_cell;
        @(posedge clock) disable iff (!arst_n)
        (cfg_mode == MODE_PTERM && ctl_en) |=>
        (cfg_mode != MODE_PTERM ||
         (cell_out & cfg_cell_reg) == ($past(cell_sum) & cfg_cell_reg));
    endproperty
    a_reg_cell: assert property (p_reg_cell) else $error("cell register wrong");

    property p_local_dup;
        @(posedge clock) disable iff (!arst_n)
        local_out[NUM_LOCAL_OUT-1] == local_out[0];
    endproperty
    a_local_dup: assert property (p_local_dup) else $error("local line mismatch");

    property p_hold_ctl;
        @(posedge clock) disable iff (!arst_n)
        (!ctl_en && cfg_mode == MODE_PTERM) |=> $stable(cell_r);
    endproperty
    a_hold_ctl: assert property (p_hold_ctl) else $error("cell moved with control low");

    property p_feedback;
        @(posedge clock) disable iff (!arst_n)
        term_in[NUM_IN +: NUM_FEEDBACK] == cell_out[NUM_FEEDBACK-1:0];
    endproperty
    a_feedback: assert property (p_feedback) else $error("feedback path wrong");

    property p_narrow;
        @(posedge clock) disable iff (!arst_n)
        (cfg_mode == MODE_MEMORY && ctl_en && rd_en && cfg_shape == SHAPE_256X8)
        |=> rd_data[15:8] == 8'h00;
    endproperty
    a_narrow: assert property (p_narrow) else $error("upper bits not zero");
endmodule

// file: hdl/embedded_array_pkg.sv
// constants for the embedded array block: memory shape, product-term layout
// assumes a single clock and configuration bits that stay static while running
package embedded_array_pkg;
    localparam int TOTAL_BITS    = 2048;           // memory bits per block
    localparam int ADDR_W        = 11;             // address for deepest shape
    localparam int DATA_W        = 16;             // widest port
    localparam int NUM_IN        = 32;             // inputs from local routing
    localparam int NUM_CELLS     = 16;             // macrocells in product-term use
    localparam int NUM_FEEDBACK  = 9;              // macrocells looped back
    localparam int NUM_LOCAL_OUT = 10;             // lines into local routing
    localparam int PAGE_W        = 2;              // page select bits for cascade
    localparam int CLK_PERIOD_NS = 40;             // 25 MHz system clock

    // memory shape codes: words x width
    typedef enum logic [2:0] {
        SHAPE_128X16  = 3'h0,
        SHAPE_256X8   = 3'h1,
        SHAPE_512X4   = 3'h2,
        SHAPE_1024X2  = 3'h3,
        SHAPE_2048X1  = 3'h4
    } shape_t;

    // block personality
    typedef enum logic {
        MODE_MEMORY = 1'h0,
        MODE_PTERM  = 1'h1
    } mode_t;

    localparam logic [DATA_W-1:0] DOUT_RESET = 16'h0000;
endpackage

// file: dv/neighbour_cells.sv
// neighbour cells model: drives the block's memory port and control lines
// assumes one clock; requests are launched just after a rising edge
`timescale 1ns/1ps
module neighbour_cells
    import embedded_array_pkg::*;
(
    input  wire logic         clock,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] wr_data,
    output logic              wr_en,
    output logic              rd_en,
    output logic              global_ctl,
    output logic              local_ctl
);
    // idle state at time zero
    initial begin
        {addr, wr_data, wr_en, rd_en} = '0;
        {global_ctl, local_ctl} = 2'h3;
    end
    // control enables from global and local sources
    task automatic set_ctl(input logic g, input logic l);
        @(posedge clock);
        global_ctl <= g;
        local_ctl  <= l;
    endtask
    // one cycle; released addr and wr_data show the inverse of the last value, wr_en and rd_en drop to zero
    task automatic op(input logic w, input logic r, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
        @(posedge clock);
        addr    <= a;
        wr_data <= d;
        wr_en   <= w;
        rd_en   <= r;
        @(posedge clock);
        addr    <= ~a;
        wr_data <= ~d;
        {wr_en, rd_en} <= 2'h0;
        #1;
    endtask
endmodule

// file: dv/testbench.sv
// testbench: memory shapes, control gating, page decode, product terms
// assumes the neighbour cells model drives the memory port
`timescale 1ns/1ps
module testbench;
    import embedded_array_pkg::*;
    logic clock = 0, arst_n = 0, cfg_mode = 0, cfg_cascade = 0;
    logic [2:0] cfg_shape = '0;
    logic [PAGE_W-1:0] page_addr = '0;
    logic [NUM_CELLS-1:0] cfg_cell_reg = '0, cell_out;
    logic [2*NUM_CELLS*(NUM_IN+NUM_FEEDBACK)-1:0] cfg_term_mask = '0;
    logic [NUM_IN-1:0] local_in = '0;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data, rd_data, rd_data_hi;
    logic rd_data_oe_hi;
    logic wr_en, rd_en, global_ctl, local_ctl, rd_data_oe;
    logic [NUM_LOCAL_OUT-1:0] local_out;
    int fails = 0, n_checks = 0, cyc = 0;
    always #(CLK_PERIOD_NS/2) clock = ~clock;
    neighbour_cells nc_i (.clock(clock), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .global_ctl(global_ctl), .local_ctl(local_ctl));
    embedded_array_block embedded_array_block_i (.clock(clock), .arst_n(arst_n),
        .cfg_mode(cfg_mode), .cfg_shape(cfg_shape), .cfg_cascade(cfg_cascade),
        .cfg_cell_reg(cfg_cell_reg), .cfg_term_mask(cfg_term_mask), .local_in(local_in),
        .global_ctl(global_ctl), .local_ctl(local_ctl), .addr(addr), .page_addr(page_addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .rd_data_oe(rd_data_oe), .cell_out(cell_out), .local_out(local_out));
    // second block side by side: shared address, inverted data, page one
    embedded_array_block #(.PAGE_ID(2'h1)) embedded_array_block_hi_i (.clock(clock),
        .arst_n(arst_n), .cfg_mode(cfg_mode), .cfg_shape(cfg_shape),
        .cfg_cascade(cfg_cascade), .cfg_cell_reg(cfg_cell_reg),
        .cfg_term_mask(cfg_term_mask), .local_in(local_in), .global_ctl(global_ctl),
        .local_ctl(local_ctl), .addr(addr), .page_addr(page_addr), .wr_data(~wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data_hi), .rd_data_oe(rd_data_oe_hi),
        .cell_out(), .local_out());
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // read one word and compare data and driver enable
    task automatic rd_chk(input logic [10:0] a, input logic [15:0] e, input logic oe);
        nc_i.op(1'b0, 1'b1, a, 16'h0);
        chk("rd_data", e, rd_data);
        chk("rd_data_oe", {15'h0, oe}, {15'h0, rd_data_oe});
    endtask
    // every shape at its deepest word, data masked to the width
    task automatic t_shapes();
        int w;
        for (int s = 0; s < 5; s++) begin
            w = 16 >> s;
            @(posedge clock);
            cfg_shape <= 3'(s);
            nc_i.op(1'b1, 1'b0, 11'((128 << s) - 1), 16'ha5c3);
            rd_chk(11'((128 << s) - 1), 16'(16'ha5c3 & ((17'h1 << w) - 1)), 1'b1);
            chk("rd_data hi", 16'(16'h5a3c & ((17'h1 << w) - 1)), rd_data_hi);
        end
    endtask
    // gated writes refused, page decode on reads and writes
    task automatic t_ctl_page();
        @(posedge clock);
        cfg_shape <= 3'h0;
        nc_i.op(1'b1, 1'b0, 11'h0, 16'h1234);
        nc_i.set_ctl(1'b0, 1'b1);
        nc_i.op(1'b1, 1'b0, 11'h0, 16'hdead);
        nc_i.set_ctl(1'b1, 1'b0);
        nc_i.op(1'b1, 1'b0, 11'h0, 16'hdead);
        nc_i.set_ctl(1'b1, 1'b1);
        rd_chk(11'h0, 16'h1234, 1'b1);
        @(posedge clock);
        cfg_cascade <= 1'b1;
        page_addr   <= 2'h1;
        nc_i.op(1'b1, 1'b0, 11'h0, 16'hbeef);
        nc_i.op(1'b0, 1'b1, 11'h0, 16'h0);
        chk("oe other page", 16'h0, {15'h0, rd_data_oe});
        chk("oe hi page", 16'h1, {15'h0, rd_data_oe_hi});
        chk("rd hi page", 16'h4110, rd_data_hi);
        @(posedge clock);
        page_addr <= 2'h0;
        rd_chk(11'h0, 16'h1234, 1'b1);
        chk("oe hi off page", 16'h0, {15'h0, rd_data_oe_hi});
    endtask
    // product terms: combinational, registered and fed-back cells
    task automatic t_pterm();
        logic [2*NUM_CELLS*(NUM_IN+NUM_FEEDBACK)-1:0] m;
        chk("cells in memory use", 16'h0, cell_out);
        m      = '0;
        m[0]   = 1'b1;
        m[124] = 1'b1;
        m[196] = 1'b1;
        @(posedge clock);
        cfg_mode        <= 1'b1;
        cfg_cell_reg    <= 16'h0002;
        cfg_term_mask   <= m;
        local_in        <= 32'h1;
        #1;
        chk("comb cells", 16'h0005, cell_out & 16'h0007);
        chk("local_out", 16'h0205, {6'h0, local_out});
        @(posedge clock);
        local_in <= 32'h2;
        @(posedge clock);
        #1;
        chk("reg cell", 16'h0002, cell_out & 16'h0007);
        chk("oe in pterm", 16'h0, {15'h0, rd_data_oe});
        nc_i.set_ctl(1'b0, 1'b1);
        @(posedge clock);
        local_in <= 32'h1;
        @(posedge clock);
        #1;
        chk("held cell", 16'h0007, cell_out & 16'h0007);
        nc_i.set_ctl(1'b1, 1'b1);
    endtask
    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        t_shapes();
        t_ctl_page();
        t_pterm();
        test_done();
    end
endmodule
